//--- hdl/rocs_dev.sv
// Purpose : receive output register clocking and receive interface clock pins
// Assumes : reference and recovered clocks far slower than CLOCK, sampled here
// Notes   : output clocks are rebuilt from sampled edges, so they carry CLOCK jitter

`timescale 1ns/1ps

module rocs_dev
   import rocs_pkg::*;
(
   input  wire logic                       CLOCK,
   input  wire logic                       RST_N,
   input  wire logic                       REFERENCE_CLOCK,
   input  wire logic [NUM_CHAN-1:0]        RECOVERED_CLOCK,
   input  wire logic [NUM_CHAN*DATA_W-1:0] RX_PARALLEL_DATA_IN,
   input  wire logic [NUM_CHAN*STAT_W-1:0] RX_CHAR_STATUS_IN,
   input  wire logic [NUM_CHAN-1:0]        RX_ODD_PARITY_IN,
   output logic      [1:0]                 MASTER_CHAN,
   rocs_if.dev                             LINK
);

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic                       ref_s1;
   logic                       ref_s2;
   logic [NUM_CHAN-1:0]        rec_s1;
   logic [NUM_CHAN-1:0]        rec_s2;
   rocs_mode_t                 mode_s1;
   rocs_mode_t                 mode_s2;
   logic                       rate_s1;
   logic                       rate_s2;
   logic [3:0]                 rxm_s1;
   logic [3:0]                 rxm_s2;
   logic                       selb_s1;
   logic                       selb_s2;
   logic                       seld_s1;
   logic                       seld_s2;

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         ref_s1  <= 1'b0;
         ref_s2  <= 1'b0;
         rec_s1  <= '0;
         rec_s2  <= '0;
         mode_s1 <= MODE_RESET;
         mode_s2 <= MODE_RESET;
         rate_s1 <= 1'b0;
         rate_s2 <= 1'b0;
         rxm_s1  <= RXM_RESET;
         rxm_s2  <= RXM_RESET;
         selb_s1 <= 1'b0;
         selb_s2 <= 1'b0;
         seld_s1 <= 1'b0;
         seld_s2 <= 1'b0;
      end
      else
      begin
         ref_s1  <= REFERENCE_CLOCK;
         ref_s2  <= ref_s1;
         rec_s1  <= RECOVERED_CLOCK;
         rec_s2  <= rec_s1;
         mode_s1 <= LINK.rx_clock_mode_sel;
         mode_s2 <= mode_s1;
         rate_s1 <= LINK.rx_clock_rate_sel;
         rate_s2 <= rate_s1;
         rxm_s1  <= LINK.rx_mode;
         rxm_s2  <= rxm_s1;
         selb_s1 <= LINK.source_select_pin_b;
         selb_s2 <= selb_s1;
         seld_s1 <= LINK.source_select_pin_d;
         seld_s2 <= seld_s1;
      end
   end

   // ----------------------------------------
   // clock state and selection
   // ----------------------------------------
   logic                       ref_d1;
   logic [NUM_CHAN-1:0]        rec_d;
   logic [NUM_CHAN-1:0]        div;
   rocs_mode_t                 mode_d;
   logic [1:0]                 settle;
   logic                       sel_b;
   logic                       sel_d;
   logic [NUM_CHAN-1:0]        clk_true;
   logic [NUM_CHAN-1:0]        clk_comp;
   logic [NUM_CHAN-1:0]        clk_oe;

   logic [NUM_CHAN-1:0]        next_div;
   logic [1:0]                 next_settle;
   logic                       next_sel_b;
   logic                       next_sel_d;
   logic [NUM_CHAN-1:0]        next_true;
   logic [NUM_CHAN-1:0]        next_oe;
   logic [NUM_CHAN-1:0]        load;
   logic [NUM_CHAN-1:0]        rise_rec;
   logic [NUM_CHAN-1:0]        lvl;
   logic                       rise_ref;
   logic [1:0]                 idx_a;
   logic [1:0]                 idx_c;

   always_comb
   begin
      rise_ref = ref_s2 & ~ref_d1;
      rise_rec = rec_s2 & ~rec_d;
      // half rate toggles on each recovered rising edge, so data moves on both output edges
      next_div = div ^ rise_rec;
      // pin level is taken from the same sample that loads the data, so both move on one edge
      lvl      = rate_s2 ? next_div : rec_s2;
      // select pins are sampled only briefly after reset or a mode change
      next_settle = (mode_s2 != mode_d) ? SEL_SETTLE : ((settle != 2'h0) ? settle - 2'h1 : 2'h0);
      next_sel_b  = (settle != 2'h0) ? selb_s2 : sel_b;
      next_sel_d  = (settle != 2'h0) ? seld_s2 : sel_d;
      if (rocs_is_dual(rxm_s2))
      begin
         idx_a = {1'b0, sel_b};
         idx_c = {1'b1, sel_d};
      end
      else
      begin
         idx_a = {sel_b, sel_d};
         idx_c = {sel_b, sel_d};
      end
      next_true = '0;
      next_oe   = OE_NONE;
      load      = '0;
      case (mode_s2)
         ROCS_MODE_LOW:
         begin
            // rate select is not looked at here
            next_true[CHAN_A] = ref_s2;
            next_true[CHAN_C] = ref_d1;
            next_oe           = OE_A_C;
            load              = {NUM_CHAN{rise_ref}};
         end
         ROCS_MODE_MID:
         begin
            next_true = lvl;
            next_oe   = OE_ALL;
            load      = rise_rec;
         end
         ROCS_MODE_HIGH:
         begin
            next_true[CHAN_A] = lvl[idx_a];
            next_true[CHAN_C] = lvl[idx_c];
            next_oe           = OE_A_C;
            if (rocs_is_dual(rxm_s2))
               load = {rise_rec[idx_c], rise_rec[idx_c], rise_rec[idx_a], rise_rec[idx_a]};
            else
               load = {NUM_CHAN{rise_rec[idx_a]}};
         end
         default:
         begin
            next_oe = OE_NONE;
         end
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         ref_d1   <= 1'b0;
         rec_d    <= '0;
         div      <= '0;
         mode_d   <= MODE_RESET;
         settle   <= SEL_SETTLE;
         sel_b    <= 1'b0;
         sel_d    <= 1'b0;
         clk_true <= '0;
         clk_comp <= '0;
         clk_oe   <= OE_NONE;
      end
      else
      begin
         ref_d1   <= ref_s2;
         rec_d    <= rec_s2;
         div      <= next_div;
         mode_d   <= mode_s2;
         settle   <= next_settle;
         sel_b    <= next_sel_b;
         sel_d    <= next_sel_d;
         clk_true <= next_true;
         clk_comp <= ~next_true;
         clk_oe   <= next_oe;
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   logic [NUM_CHAN*DATA_W-1:0] data_q;
   logic [NUM_CHAN*STAT_W-1:0] stat_q;
   logic [NUM_CHAN-1:0]        par_q;
   logic [NUM_CHAN*DATA_W-1:0] next_data;
   logic [NUM_CHAN*STAT_W-1:0] next_stat;
   logic [NUM_CHAN-1:0]        next_par;

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++)
      begin : g_chan
         always_comb
         begin
            next_data[g*DATA_W +: DATA_W] = load[g] ? RX_PARALLEL_DATA_IN[g*DATA_W +: DATA_W]
                                                    : data_q[g*DATA_W +: DATA_W];
            next_stat[g*STAT_W +: STAT_W] = load[g] ? RX_CHAR_STATUS_IN[g*STAT_W +: STAT_W]
                                                    : stat_q[g*STAT_W +: STAT_W];
            next_par[g]                   = load[g] ? RX_ODD_PARITY_IN[g] : par_q[g];
         end
      end
   endgenerate

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         data_q <= '0;
         stat_q <= '0;
         par_q  <= '0;
      end
      else
      begin
         data_q <= next_data;
         stat_q <= next_stat;
         par_q  <= next_par;
      end
   end

   assign LINK.rx_clk_drv_true   = clk_true;
   assign LINK.rx_clk_drv_comp   = clk_comp;
   assign LINK.rx_clk_oe         = clk_oe;
   assign LINK.rx_parallel_data  = data_q;
   assign LINK.rx_char_status    = stat_q;
   assign LINK.rx_odd_parity_out = par_q;
   assign MASTER_CHAN            = {sel_b, sel_d};

endmodule // rocs_dev

//--- hdl/rocs_host.sv
// Purpose : downstream logic latching receive data on the receive interface clocks
// Assumes : user requests are static while the link runs
// Notes   : pin clocks pass two flops, so captures lag the pin edge by three cycles

`timescale 1ns/1ps

module rocs_host
   import rocs_pkg::*;
(
   input  wire logic                       CLOCK,
   input  wire logic                       RST_N,
   input  wire rocs_mode_t                 MODE_REQ,
   input  wire logic                       RATE_REQ,
   input  wire logic [3:0]                 RXMODE_REQ,
   input  wire logic                       MULTI_DEVICE_BOND,
   input  wire logic                       DECODER_BYPASS,
   input  wire logic [1:0]                 MASTER_SEL,
   output logic      [NUM_CHAN*DATA_W-1:0] DATA_OUT,
   output logic      [NUM_CHAN*STAT_W-1:0] STATUS_OUT,
   output logic      [NUM_CHAN-1:0]        PARITY_OUT,
   output logic      [NUM_CHAN-1:0]        DATA_STROBE,
   rocs_if.host                            LINK
);

   // ----------------------------------------
   // static configuration
   // ----------------------------------------
   rocs_mode_t                 mode;
   logic                       rate;
   logic [3:0]                 rxm;
   logic [1:0]                 msel;
   rocs_mode_t                 next_mode;

   always_comb
   begin
      if (DECODER_BYPASS)
         next_mode = ROCS_MODE_MID;
      else if (MULTI_DEVICE_BOND)
         next_mode = ROCS_MODE_LOW;
      else
         next_mode = MODE_REQ;
   end

   // ----------------------------------------
   // pin sampling and capture
   // ----------------------------------------
   logic [NUM_CHAN-1:0]        t_s1;
   logic [NUM_CHAN-1:0]        t_s2;
   logic [NUM_CHAN-1:0]        t_d;
   logic [NUM_CHAN-1:0]        c_s1;
   logic [NUM_CHAN-1:0]        c_s2;
   logic [NUM_CHAN-1:0]        c_d;
   logic [NUM_CHAN*DATA_W-1:0] d_s1;
   logic [NUM_CHAN*DATA_W-1:0] d_s2;
   logic [NUM_CHAN*STAT_W-1:0] s_s1;
   logic [NUM_CHAN*STAT_W-1:0] s_s2;
   logic [NUM_CHAN-1:0]        p_s1;
   logic [NUM_CHAN-1:0]        p_s2;
   logic [NUM_CHAN-1:0]        pin_rise;
   logic [NUM_CHAN-1:0]        next_strobe;
   logic [NUM_CHAN*DATA_W-1:0] next_data;
   logic [NUM_CHAN*STAT_W-1:0] next_stat;
   logic [NUM_CHAN-1:0]        next_par;
   logic                       use_comp;

   always_comb
   begin
      // half rate outside low mode: both true and complement rising edges carry a word
      use_comp = rate && (mode != ROCS_MODE_LOW);
      pin_rise = (t_s2 & ~t_d) | ({NUM_CHAN{use_comp}} & c_s2 & ~c_d);
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++)
      begin : g_chan
         logic [1:0] tp;
         always_comb
         begin
            tp = 2'(CHAN_A);
            case (mode)
               ROCS_MODE_LOW:  tp = 2'(CHAN_A);
               ROCS_MODE_MID:  tp = 2'(g);
               ROCS_MODE_HIGH: tp = (rocs_is_dual(rxm) && (g >= CHAN_C)) ? 2'(CHAN_C) : 2'(CHAN_A);
               default:        tp = 2'(CHAN_A);
            endcase
            next_strobe[g]                = pin_rise[tp];
            next_data[g*DATA_W +: DATA_W] = pin_rise[tp] ? d_s2[g*DATA_W +: DATA_W] : DATA_OUT[g*DATA_W +: DATA_W];
            next_stat[g*STAT_W +: STAT_W] = pin_rise[tp] ? s_s2[g*STAT_W +: STAT_W]
                                                         : STATUS_OUT[g*STAT_W +: STAT_W];
            next_par[g]                   = pin_rise[tp] ? p_s2[g] : PARITY_OUT[g];
         end
      end
   endgenerate

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         mode        <= MODE_RESET;
         rate        <= 1'b0;
         rxm         <= RXM_RESET;
         msel        <= 2'h0;
         t_s1        <= '0;
         t_s2        <= '0;
         t_d         <= '0;
         c_s1        <= '0;
         c_s2        <= '0;
         c_d         <= '0;
         d_s1        <= '0;
         d_s2        <= '0;
         s_s1        <= '0;
         s_s2        <= '0;
         p_s1        <= '0;
         p_s2        <= '0;
         DATA_OUT    <= '0;
         STATUS_OUT  <= '0;
         PARITY_OUT  <= '0;
         DATA_STROBE <= '0;
      end
      else
      begin
         mode        <= next_mode;
         rate        <= RATE_REQ;
         rxm         <= RXMODE_REQ;
         msel        <= MASTER_SEL;
         t_s1        <= LINK.rx_clk_pin_true;
         t_s2        <= t_s1;
         t_d         <= t_s2;
         c_s1        <= LINK.rx_clk_pin_comp;
         c_s2        <= c_s1;
         c_d         <= c_s2;
         d_s1        <= LINK.rx_parallel_data;
         d_s2        <= d_s1;
         s_s1        <= LINK.rx_char_status;
         s_s2        <= s_s1;
         p_s1        <= LINK.rx_odd_parity_out;
         p_s2        <= p_s1;
         DATA_OUT    <= next_data;
         STATUS_OUT  <= next_stat;
         PARITY_OUT  <= next_par;
         DATA_STROBE <= next_strobe;
      end
   end

   assign LINK.rx_clock_mode_sel = mode;
   assign LINK.rx_clock_rate_sel = rate;
   assign LINK.rx_mode           = rxm;
   assign LINK.sel_drv_b         = msel[1];
   assign LINK.sel_drv_d         = msel[0];
   // selects are driven in low and high modes, where the device leaves the B and D pins undriven
   assign LINK.sel_oe            = (mode != ROCS_MODE_MID);

endmodule // rocs_host

//--- pkg/rocs_if.sv
// Purpose : pins between the receive output clock end and downstream logic
// Assumes : static control pins driven by downstream logic
// Notes   : shared clock pins resolved here from the two output enables

`timescale 1ns/1ps

interface rocs_if;
   import rocs_pkg::*;

   // ----------------------------------------
   // driven by the device end
   // ----------------------------------------
   logic [3:0]                 rx_clk_drv_true;
   logic [3:0]                 rx_clk_drv_comp;
   logic [3:0]                 rx_clk_oe;
   logic [NUM_CHAN*DATA_W-1:0] rx_parallel_data;
   logic [NUM_CHAN*STAT_W-1:0] rx_char_status;
   logic [NUM_CHAN-1:0]        rx_odd_parity_out;

   // ----------------------------------------
   // driven by downstream logic
   // ----------------------------------------
   rocs_mode_t                 rx_clock_mode_sel;
   logic                       rx_clock_rate_sel;
   logic [3:0]                 rx_mode;
   logic                       sel_drv_b;
   logic                       sel_drv_d;
   logic                       sel_oe;

   // ----------------------------------------
   // resolved pin levels
   // ----------------------------------------
   logic [3:0]                 rx_clk_pin_true;
   logic [3:0]                 rx_clk_pin_comp;
   logic                       source_select_pin_b;
   logic                       source_select_pin_d;

   // an undriven pin reads low, as if pulled down
   assign source_select_pin_b = rx_clk_oe[CHAN_B] ? rx_clk_drv_true[CHAN_B] : (sel_oe & sel_drv_b);
   assign source_select_pin_d = rx_clk_oe[CHAN_D] ? rx_clk_drv_true[CHAN_D] : (sel_oe & sel_drv_d);
   assign rx_clk_pin_true     = {source_select_pin_d, rx_clk_oe[CHAN_C] & rx_clk_drv_true[CHAN_C],
                                 source_select_pin_b, rx_clk_oe[CHAN_A] & rx_clk_drv_true[CHAN_A]};
   assign rx_clk_pin_comp     = rx_clk_oe & rx_clk_drv_comp;

   modport dev (
      output rx_clk_drv_true,
      output rx_clk_drv_comp,
      output rx_clk_oe,
      output rx_parallel_data,
      output rx_char_status,
      output rx_odd_parity_out,
      input  rx_clock_mode_sel,
      input  rx_clock_rate_sel,
      input  rx_mode,
      input  source_select_pin_b,
      input  source_select_pin_d
   );

   modport host (
      input  rx_clk_pin_true,
      input  rx_clk_pin_comp,
      input  rx_parallel_data,
      input  rx_char_status,
      input  rx_odd_parity_out,
      output rx_clock_mode_sel,
      output rx_clock_rate_sel,
      output rx_mode,
      output sel_drv_b,
      output sel_drv_d,
      output sel_oe
   );

endinterface // rocs_if

//--- pkg/rocs_pkg.sv
// Purpose : shared constants and types for the receive output clock select block
// Assumes : four channels, eight data bits, three status bits and one parity bit each
// Notes   : three-level pins are carried as a one-hot mode type

package rocs_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NUM_CHAN = 4;
   localparam int DATA_W   = 8;
   localparam int STAT_W   = 3;
   localparam int CHAN_A   = 0;
   localparam int CHAN_B   = 1;
   localparam int CHAN_C   = 2;
   localparam int CHAN_D   = 3;

   // ----------------------------------------
   // three-level clock mode pin
   // ----------------------------------------
   typedef enum logic [2:0] {
      ROCS_MODE_LOW  = 3'h1,
      ROCS_MODE_MID  = 3'h2,
      ROCS_MODE_HIGH = 3'h4
   } rocs_mode_t;

   localparam rocs_mode_t MODE_RESET = ROCS_MODE_MID;

   // ----------------------------------------
   // receive operating modes
   // ----------------------------------------
   localparam logic [3:0] RXM_IND_0  = 4'h0;
   localparam logic [3:0] RXM_IND_2  = 4'h2;
   localparam logic [3:0] RXM_DUAL_3 = 4'h3;
   localparam logic [3:0] RXM_DUAL_5 = 4'h5;
   localparam logic [3:0] RXM_QUAD_6 = 4'h6;
   localparam logic [3:0] RXM_QUAD_8 = 4'h8;
   localparam logic [3:0] RXM_RESET  = 4'h0;

   // ----------------------------------------
   // output enables and timing
   // ----------------------------------------
   localparam logic [3:0] OE_ALL     = 4'hF;
   localparam logic [3:0] OE_A_C     = 4'h5;
   localparam logic [3:0] OE_NONE    = 4'h0;
   localparam logic [1:0] SEL_SETTLE = 2'h3;

   function automatic logic rocs_is_dual(input logic [3:0] m);
      return (m == RXM_DUAL_3) || (m == RXM_DUAL_5);
   endfunction

   function automatic logic rocs_is_quad(input logic [3:0] m);
      return (m == RXM_QUAD_6) || (m == RXM_QUAD_8);
   endfunction

endpackage

//--- verif/rocs_props.sv
// Purpose: link pin checks for the joined ends
// Assumes: mode held 8 cycles covers resync
// Notes: watches interface signals only
`timescale 1ns/1ps
module rocs_props
   import rocs_pkg::*;
(
   input wire logic                       CLOCK,
   input wire logic                       RST_N,
   input wire logic [3:0]                 rx_clk_drv_true,
   input wire logic [3:0]                 rx_clk_drv_comp,
   input wire logic [3:0]                 rx_clk_oe,
   input wire logic [NUM_CHAN*DATA_W-1:0] rx_parallel_data,
   input wire rocs_mode_t                 rx_clock_mode_sel,
   input wire logic                       rx_clock_rate_sel,
   input wire logic [3:0]                 rx_mode
);
   // ----
   // settled modes
   // ----
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   sequence s_low;
      (rx_clock_mode_sel == ROCS_MODE_LOW)[*8];
   endsequence
   sequence s_mid;
      (rx_clock_mode_sel == ROCS_MODE_MID)[*8];
   endsequence
   sequence s_high;
      (rx_clock_mode_sel == ROCS_MODE_HIGH)[*8];
   endsequence
   sequence s_full;
      (rx_clock_mode_sel == ROCS_MODE_MID && !rx_clock_rate_sel)[*8];
   endsequence
   AST_LOW_OE : assert property (s_low |-> rx_clk_oe == OE_A_C)
      else $error("low mode enables wrong");
   AST_MID_OE : assert property (s_mid |-> rx_clk_oe == OE_ALL)
      else $error("mid mode enables wrong");
   AST_HIGH_OE : assert property (s_high |-> rx_clk_oe == OE_A_C)
      else $error("high mode enables wrong");
   AST_COMP : assert property ((rx_clk_drv_comp & rx_clk_oe) == (~rx_clk_drv_true & rx_clk_oe))
      else $error("complement clock not inverse");
   AST_LOW_PHASE : assert property (s_low |-> rx_clk_drv_true[CHAN_C] == $past(rx_clk_drv_true[CHAN_A]))
      else $error("reference copies not one cycle apart");
   AST_HIGH_SAME : assert property (s_high ##0 (rx_mode == RXM_QUAD_6 || rx_mode == RXM_QUAD_8
      || rx_mode == RXM_IND_0 || rx_mode == RXM_IND_2) |-> rx_clk_drv_true[CHAN_A] == rx_clk_drv_true[CHAN_C])
      else $error("pins A and C differ");
   AST_DATA_CLK : assert property ($changed(rx_parallel_data) |-> $changed(rx_clk_drv_true))
      else $error("data moved without clock");
   AST_FULL_RATE : assert property (s_full ##0 $changed(rx_parallel_data[7:0])
      |-> $rose(rx_clk_drv_true[CHAN_A]))
      else $error("full rate data not on rise");
endmodule // rocs_props

//--- verif/rocs_tb_top.sv
// Purpose: self-checking bench, both ends joined
// Assumes: recovered clocks 160 ns, staggered 2 cycles
// Notes: counts span whole periods, so they are exact
`timescale 1ns/1ps
module rocs_tb_top;
   import rocs_pkg::*;
   // ----
   // stimulus and instances
   // ----
   logic        CLOCK, RST_N, ref_clk, bond, bypass, rate;
   logic [3:0]  rec, rxm, st, pout;
   logic [1:0]  sel, mchan;
   rocs_mode_t  mode;
   logic [31:0] pat, dout;
   logic [11:0] sout;
   int          cnt, err_total, cmp_count;
   int          rises[4], phase[4], strb[4], own[4];
   rocs_if rocs_if_i ();
   rocs_dev rocs_dev_i (.CLOCK(CLOCK), .RST_N(RST_N), .REFERENCE_CLOCK(ref_clk), .RECOVERED_CLOCK(rec),
      .RX_PARALLEL_DATA_IN(pat), .RX_CHAR_STATUS_IN(pat[11:0]), .RX_ODD_PARITY_IN(pat[3:0]),
      .MASTER_CHAN(mchan), .LINK(rocs_if_i.dev));
   rocs_host rocs_host_i (.CLOCK(CLOCK), .RST_N(RST_N), .MODE_REQ(mode), .RATE_REQ(rate), .RXMODE_REQ(rxm),
      .MULTI_DEVICE_BOND(bond), .DECODER_BYPASS(bypass), .MASTER_SEL(sel), .DATA_OUT(dout),
      .STATUS_OUT(sout), .PARITY_OUT(pout), .DATA_STROBE(st), .LINK(rocs_if_i.host));
   rocs_props rocs_props_i (.CLOCK(CLOCK), .RST_N(RST_N), .rx_clk_drv_true(rocs_if_i.rx_clk_drv_true),
      .rx_clk_drv_comp(rocs_if_i.rx_clk_drv_comp), .rx_clk_oe(rocs_if_i.rx_clk_oe),
      .rx_parallel_data(rocs_if_i.rx_parallel_data), .rx_clock_mode_sel(rocs_if_i.rx_clock_mode_sel),
      .rx_clock_rate_sel(rocs_if_i.rx_clock_rate_sel), .rx_mode(rocs_if_i.rx_mode));
   initial
   begin
      CLOCK = 0;
      forever #5 CLOCK = ~CLOCK;
   end
   // recovered clocks stepped off CLOCK so every window is a whole number of periods
   initial
   begin
      cnt = 0;
      rec = '0;
      ref_clk = 0;
      forever
      begin
         @(posedge CLOCK);
         // count on the edge itself so readers at the stimulus delay never race it
         cnt++;
         #1;
         ref_clk = (cnt % 10) < 5;
         for (int g = 0; g < 4; g++)
            rec[g] = ((cnt + 2 * g) % 16) < 8;
      end
   end
   // ----
   // helpers
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // passing through mid first forces the device to re-latch the selects
   task automatic setup(input rocs_mode_t m, input logic r, input logic [3:0] x, input logic [1:0] s,
                        input logic b, input logic p);
      mode = ROCS_MODE_MID;
      bond = 0;
      bypass = 0;
      tick(10);
      mode = m;
      rate = r;
      rxm = x;
      sel = s;
      bond = b;
      bypass = p;
      tick(40);
   endtask
   task automatic run_window();
      logic [3:0] prev;
      pat = pat + 32'h13579BDF;
      for (int g = 0; g < 4; g++)
      begin
         rises[g] = 0;
         strb[g] = 0;
         phase[g] = -1;
      end
      prev = rocs_if_i.rx_clk_pin_true;
      repeat (320)
      begin
         tick(1);
         for (int g = 0; g < 4; g++)
         begin
            if (rocs_if_i.rx_clk_pin_true[g] && !prev[g])
            begin
               rises[g]++;
               phase[g] = cnt % 16;
            end
            if (st[g] === 1'b1)
               strb[g]++;
         end
         prev = rocs_if_i.rx_clk_pin_true;
      end
      chk("data", pat, dout);
      chk("status", pat[11:0], sout);
      chk("parity", pat[3:0], pout);
   endtask
   // ----
   // scenarios
   // ----
   task automatic mid_modes();
      for (int r = 0; r < 2; r++)
      begin
         setup(ROCS_MODE_MID, r[0], RXM_IND_0, 2'h0, 0, 0);
         run_window();
         for (int g = 0; g < 4; g++)
         begin
            chk("own rises", r ? 10 : 20, rises[g]);
            chk("strobes", 20, strb[g]);
            chk("own phase", (phase[0] + 16 - 2 * g) % 16, phase[g]);
            own[g] = phase[g];
         end
      end
   endtask
   task automatic bypass_mode();
      setup(ROCS_MODE_HIGH, 0, RXM_QUAD_6, 2'h3, 0, 1);
      run_window();
      for (int g = 0; g < 4; g++)
         chk("bypass phase", own[g], phase[g]);
   endtask
   task automatic low_mode();
      setup(ROCS_MODE_MID, 1, RXM_QUAD_6, 2'h2, 1, 0);
      run_window();
      chk("pin A rises", 32, rises[0]);
      chk("pin C rises", 32, rises[2]);
      chk("B D enables", 0, {rocs_if_i.rx_clk_oe[3], rocs_if_i.rx_clk_oe[1]});
      chk("master", 2'h2, mchan);
      for (int g = 0; g < 4; g++)
         chk("ref strobes", 32, strb[g]);
   endtask
   task automatic high_sel();
      logic [3:0] modes[4] = '{RXM_IND_0, RXM_IND_2, RXM_QUAD_6, RXM_QUAD_8};
      for (int i = 0; i < 4; i++)
      begin
         setup(ROCS_MODE_HIGH, i == 3, modes[i], i[1:0], 0, 0);
         run_window();
         chk("pin A rises", i == 3 ? 10 : 20, rises[0]);
         chk("pin A phase", own[i], phase[0]);
         chk("pin C phase", own[i], phase[2]);
      end
      sel = 2'h0;
      tick(40);
      run_window();
      chk("held phase", own[3], phase[0]);
   endtask
   task automatic dual_sel();
      for (int d = 0; d < 2; d++)
      begin
         setup(ROCS_MODE_HIGH, 0, d ? RXM_DUAL_5 : RXM_DUAL_3, d ? 2'h1 : 2'h2, 0, 0);
         run_window();
         chk("dual A phase", own[d ? 0 : 1], phase[0]);
         chk("dual C phase", own[d ? 3 : 2], phase[2]);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      RST_N = 0;
      mode = ROCS_MODE_MID;
      rate = 1'b0;
      rxm = 4'h0;
      sel = 2'h0;
      bond = 1'b0;
      bypass = 1'b0;
      pat = 32'hA5C30F96;
      err_total = 0;
      cmp_count = 0;
      tick(3);
      RST_N = 1;
      tick(6);
      mid_modes();
      bypass_mode();
      low_mode();
      high_sel();
      dual_sel();
      complete_run();
   end
   // about four thousand cycles are expected; about five times that cuts a hang
   initial
   begin
      #200us;
      err_total++;
      complete_run();
   end
endmodule // rocs_tb_top
